// [core/fci_pkg.sv]
// Package: constants for the flash command interface host controller
`default_nettype none
package fci_pkg;
  localparam int          ADDR_W          = 19;
  localparam int          DATA_W          = 8;
  localparam int          CLK_PERIOD_NS   = 20;
  // Commands
  localparam logic [7:0]  CMD_READ_ARRAY  = 8'hff;
  localparam logic [7:0]  CMD_READ_STATUS = 8'h70;
  localparam logic [7:0]  CMD_READ_SIG    = 8'h90;
  localparam logic [7:0]  CMD_PROG_A      = 8'h40;
  localparam logic [7:0]  CMD_PROG_B      = 8'h10;
  localparam logic [7:0]  CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0]  CMD_CONFIRM     = 8'hd0;
  localparam logic [7:0]  CMD_CLEAR_STAT  = 8'h50;
  localparam logic [7:0]  CMD_SUSPEND     = 8'hb0;
  // Status bits
  localparam int          ST_READY_BIT    = 7;
  localparam int          ST_ERASE_ERR    = 5;
  localparam int          ST_PROG_ERR     = 4;
  localparam logic [7:0]  ST_ERR_MASK     = 8'h3a;
  // Block map (byte addresses, boot at top variant)
  localparam logic [18:0] BOOT_TOP_BASE   = 19'h7c000;
  localparam logic [18:0] BOOT_SIZE       = 19'h04000;
  // Wake-up times after deep power-down
  localparam int          WAKE_READ_NS    = 600;
  localparam int          WAKE_CMD_NS     = 480;
  localparam int          WAKE_READ_CYC   = (WAKE_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          WAKE_CMD_CYC    = (WAKE_CMD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Bus cycle phase lengths
  localparam int          SETUP_CYC       = 2;
  localparam int          STROBE_CYC      = 4;
  localparam int          HOLD_CYC        = 2;
  localparam int          CNT_W           = 8;
  // Host operations
  typedef enum logic [3:0] {
    OP_READ_ARRAY  = 4'h0,
    OP_READ_STATUS = 4'h1,
    OP_READ_SIG    = 4'h2,
    OP_PROGRAM     = 4'h3,
    OP_ERASE       = 4'h4,
    OP_CLEAR_STAT  = 4'h5,
    OP_SUSPEND     = 4'h6,
    OP_RESUME      = 4'h7,
    OP_READ        = 4'h8
  } fci_op_t;
endpackage
`default_nettype wire

// [core/fci_bus_cycle.sv]
// One asynchronous bus cycle (read or write) on the flash pins
`default_nettype none
module fci_bus_cycle
  import fci_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              start,
  input  wire logic              is_write,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [DATA_W-1:0] dq_i,
  output logic                   chip_en_b,
  output logic                   out_en_b,
  output logic                   wr_en_b,
  output logic [ADDR_W-1:0]      addr_o,
  output logic [DATA_W-1:0]      dq_o,
  output logic                   dq_oe,
  output logic [DATA_W-1:0]      rdata,
  output logic                   done
);
  typedef enum logic [3:0] {
    BC_IDLE   = 4'b0001,
    BC_SETUP  = 4'b0010,
    BC_STROBE = 4'b0100,
    BC_HOLD   = 4'b1000
  } fci_bc_t;

  fci_bc_t          st_r;
  logic [CNT_W-1:0] cnt_r;
  logic             wr_r;

  ////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_r      <= BC_IDLE;
      cnt_r     <= '0;
      wr_r      <= 1'b0;
      chip_en_b <= 1'b1;
      out_en_b  <= 1'b1;
      wr_en_b   <= 1'b1;
      addr_o    <= '0;
      dq_o      <= '0;
      dq_oe     <= 1'b0;
      rdata     <= '0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (st_r)
        BC_IDLE: begin
          if (start) begin
            st_r      <= BC_SETUP;
            cnt_r     <= CNT_W'(SETUP_CYC - 1);
            wr_r      <= is_write;
            addr_o    <= addr;
            dq_o      <= wdata;
            dq_oe     <= is_write;
            chip_en_b <= 1'b0;
          end
        end
        BC_SETUP: begin
          if (cnt_r == '0) begin
            st_r     <= BC_STROBE;
            cnt_r    <= CNT_W'(STROBE_CYC - 1);
            // Write cycle strobes write enable, read strobes output enable
            wr_en_b  <= !wr_r;
            out_en_b <= wr_r;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        BC_STROBE: begin
          if (cnt_r == '0) begin
            st_r     <= BC_HOLD;
            cnt_r    <= CNT_W'(HOLD_CYC - 1);
            wr_en_b  <= 1'b1;
            out_en_b <= 1'b1;
            if (!wr_r) begin
              rdata <= dq_i;
            end
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        BC_HOLD: begin
          if (cnt_r == '0) begin
            st_r      <= BC_IDLE;
            chip_en_b <= 1'b1;
            dq_oe     <= 1'b0;
            done      <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [core/fci_host.sv]
// Host controller that drives a byte-wide block-erase flash over its pins
// Operation
// - FFh/70h/90h select array/status/signature reads
// - Program 40h/10h then data; erase 20h/D0h
// - B0h suspends erase, D0h resumes it
// - Boot block changes need unlock level first
// - Wait 600 ns reads, 480 ns commands after wake
// - Five bus operation types via enables
`default_nettype none
module fci_host
  import fci_pkg::*;
#(
  parameter bit                  BOOT_AT_TOP = 1'b1
)
(
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              req_valid,
  input  wire fci_pkg::fci_op_t  req_op,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_data,
  input  wire logic              pwr_down_req,
  input  wire logic              boot_unlock_req,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_data,
  output logic                   rsp_refused,
  output logic                   chip_en_b,
  output logic                   out_en_b,
  output logic                   wr_en_b,
  output logic [ADDR_W-1:0]      addr_o,
  input  wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0]      dq_o,
  output logic                   dq_oe,
  output logic                   pdl_low,
  output logic                   pdl_high_volt
);
  import fci_pkg::*;

  typedef enum logic [6:0] {
    H_IDLE   = 7'b0000001,
    H_CYC1   = 7'b0000010,
    H_WAIT1  = 7'b0000100,
    H_CYC2   = 7'b0001000,
    H_WAIT2  = 7'b0010000,
    H_DOWN   = 7'b0100000,
    H_WAKE   = 7'b1000000
  } fci_host_st_t;

  fci_host_st_t     st_r;
  fci_op_t          op_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] data_r;
  logic [CNT_W-1:0] wake_cnt_r;
  logic             cmd_ok_r;
  logic             bc_start_r;
  logic             bc_wr_r;
  logic [ADDR_W-1:0] bc_addr_r;
  logic [DATA_W-1:0] bc_wdata_r;
  logic             bc_done;
  logic [DATA_W-1:0] bc_rdata;
  logic             in_boot;
  logic [7:0]       first_cmd;
  logic             two_cycle;
  logic             second_is_read;

  ////////////////////////////////////////////////////////////
  // Block map: boot block is the top or bottom 16K
  assign in_boot = BOOT_AT_TOP ? (req_addr >= BOOT_TOP_BASE) : (req_addr < BOOT_SIZE);

  always_comb begin
    first_cmd      = CMD_READ_ARRAY;
    two_cycle      = 1'b0;
    second_is_read = 1'b0;
    unique case (req_op)
      OP_READ_ARRAY:  begin first_cmd = CMD_READ_ARRAY; end
      OP_READ_STATUS: begin first_cmd = CMD_READ_STATUS; two_cycle = 1'b1; second_is_read = 1'b1; end
      OP_READ_SIG:    begin first_cmd = CMD_READ_SIG; two_cycle = 1'b1; second_is_read = 1'b1; end
      OP_PROGRAM:     begin first_cmd = CMD_PROG_A; two_cycle = 1'b1; end
      OP_ERASE:       begin first_cmd = CMD_ERASE_SETUP; two_cycle = 1'b1; end
      OP_CLEAR_STAT:  begin first_cmd = CMD_CLEAR_STAT; end
      OP_SUSPEND:     begin first_cmd = CMD_SUSPEND; end
      OP_RESUME:      begin first_cmd = CMD_CONFIRM; end
      OP_READ:        begin first_cmd = CMD_READ_ARRAY; second_is_read = 1'b1; end
      default:        begin first_cmd = CMD_READ_ARRAY; end
    endcase
  end

  fci_bus_cycle u_cyc (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .start     (bc_start_r),
    .is_write  (bc_wr_r),
    .addr      (bc_addr_r),
    .wdata     (bc_wdata_r),
    .dq_i      (dq_i),
    .chip_en_b (chip_en_b),
    .out_en_b  (out_en_b),
    .wr_en_b   (wr_en_b),
    .addr_o    (addr_o),
    .dq_o      (dq_o),
    .dq_oe     (dq_oe),
    .rdata     (bc_rdata),
    .done      (bc_done)
  );

  ////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      // Lock pin is at ground in reset, so leave through the wake wait
      st_r        <= H_DOWN;
      op_r        <= OP_READ_ARRAY;
      addr_r      <= '0;
      data_r      <= '0;
      wake_cnt_r  <= '0;
      cmd_ok_r    <= 1'b0;
      bc_start_r  <= 1'b0;
      bc_wr_r     <= 1'b0;
      bc_addr_r   <= '0;
      bc_wdata_r  <= '0;
      req_ready   <= 1'b0;
      rsp_valid   <= 1'b0;
      rsp_data    <= '0;
      rsp_refused <= 1'b0;
      pdl_low     <= 1'b1;
    end else begin
      bc_start_r  <= 1'b0;
      rsp_valid   <= 1'b0;
      rsp_refused <= 1'b0;
      unique case (st_r)
        H_IDLE: begin
          if (pwr_down_req) begin
            // Lock pin to ground: device drops into deep power-down
            st_r      <= H_DOWN;
            req_ready <= 1'b0;
            pdl_low   <= 1'b1;
          end else if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            if ((req_op == OP_PROGRAM || req_op == OP_ERASE) && in_boot && !pdl_high_volt) begin
              // Boot block untouched without unlock level
              rsp_valid   <= 1'b1;
              rsp_refused <= 1'b1;
              st_r        <= H_WAIT2;
            end else begin
              op_r       <= req_op;
              addr_r     <= req_addr;
              data_r     <= (req_op == OP_ERASE) ? CMD_CONFIRM : req_data;
              bc_start_r <= 1'b1;
              bc_wr_r    <= (req_op != OP_READ);
              bc_addr_r  <= req_addr;
              bc_wdata_r <= first_cmd;
              cmd_ok_r   <= two_cycle || second_is_read;
              st_r       <= H_CYC1;
            end
          end else begin
            req_ready <= 1'b1;
          end
        end
        H_CYC1: begin
          if (bc_done) begin
            if (op_r == OP_READ) begin
              rsp_valid <= 1'b1;
              rsp_data  <= bc_rdata;
              st_r      <= H_WAIT2;
            end else if (cmd_ok_r) begin
              st_r <= H_WAIT1;
            end else begin
              rsp_valid <= 1'b1;
              st_r      <= H_WAIT2;
            end
          end
        end
        H_WAIT1: begin
          // Second cycle: data or confirm write, or read of selected source
          bc_start_r <= 1'b1;
          bc_wr_r    <= !(op_r == OP_READ_STATUS || op_r == OP_READ_SIG);
          bc_addr_r  <= addr_r;
          bc_wdata_r <= data_r;
          st_r       <= H_CYC2;
        end
        H_CYC2: begin
          if (bc_done) begin
            rsp_valid <= 1'b1;
            rsp_data  <= bc_rdata;
            st_r      <= H_WAIT2;
          end
        end
        H_WAIT2: begin
          req_ready <= 1'b1;
          st_r      <= H_IDLE;
        end
        H_DOWN: begin
          if (!pwr_down_req) begin
            pdl_low    <= 1'b0;
            wake_cnt_r <= CNT_W'(WAKE_READ_CYC);
            st_r       <= H_WAKE;
          end
        end
        H_WAKE: begin
          // Hold off all bus use until the longer wake time passes
          if (wake_cnt_r == '0) begin
            req_ready <= 1'b1;
            st_r      <= H_IDLE;
          end else begin
            wake_cnt_r <= wake_cnt_r - 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // Unlock level changes only while the bus is quiet
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pdl_high_volt <= 1'b0;
    end else if (st_r == H_IDLE && (pwr_down_req || !req_valid)) begin
      pdl_high_volt <= boot_unlock_req && !pwr_down_req;
    end
  end
endmodule
`default_nettype wire

// [testbench/fci_host_monitor.sv]
// Pin and response protocol checker for the flash host
`default_nettype none
module fci_host_monitor
  import fci_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic rsp_valid,
  input wire logic rsp_refused,
  input wire logic chip_en_b,
  input wire logic out_en_b,
  input wire logic wr_en_b,
  input wire logic dq_oe,
  input wire logic pdl_low,
  input wire logic pdl_high_volt
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] wake_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Cycles since the lock pin left ground
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      wake_r <= 6'h0;
    else if (pdl_low)
      wake_r <= 6'h0;
    else if (wake_r != 6'h3f)
      wake_r <= wake_r + 6'h1;
  end
  AST_STROBE_EXCL: assert property (!(!out_en_b && !wr_en_b))
    else $error("read and write strobes low together");
  AST_WE_CE: assert property (!wr_en_b |-> !chip_en_b && dq_oe)
    else $error("write strobe without select or data");
  AST_OE_CE: assert property (!out_en_b |-> !chip_en_b && !dq_oe)
    else $error("read strobe while driving data");
  AST_LOCK_EXCL: assert property (!(pdl_low && pdl_high_volt))
    else $error("lock pin at ground and unlock level");
  AST_DOWN_IDLE: assert property (pdl_low |-> chip_en_b)
    else $error("bus used in deep power-down");
  AST_WAKE_CMD: assert property (!wr_en_b |-> wake_r >= WAKE_CMD_CYC)
    else $error("command written too soon after wake");
  AST_WAKE_RD: assert property (!out_en_b |-> wake_r >= WAKE_READ_CYC)
    else $error("read too soon after wake");
  AST_WE_WIDTH: assert property ($fell(wr_en_b) |-> (!wr_en_b)[*4] ##1 wr_en_b)
    else $error("write strobe width wrong");
  AST_REFUSE: assert property (rsp_refused |-> rsp_valid && chip_en_b && $past(chip_en_b))
    else $error("refusal with a bus cycle");
  AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
  COV_REFUSED: cover property (rsp_refused);
  COV_WRITE: cover property ($fell(wr_en_b));
  COV_READ: cover property ($fell(out_en_b));
endmodule
bind fci_host fci_host_monitor mon (.mclk, .rst_b, .rsp_valid, .rsp_refused, .chip_en_b, .out_en_b,
  .wr_en_b, .dq_oe, .pdl_low, .pdl_high_volt);
`default_nettype wire

// [testbench/fci_flash_model.sv]
// Behavioural byte-wide flash device on the host pins
`default_nettype none
module fci_flash_model
  import fci_pkg::*;
#(
  parameter logic [7:0] SIG_CODE  = 8'h5a, // Arbitrary value
  parameter int         PROG_CYC  = 60,
  parameter int         ERASE_CYC = 300
)
(
  input  wire logic [18:0] addr_o,
  input  wire logic [7:0]  dq_o,
  input  wire logic        mclk,
  input  wire logic        chip_en_b,
  input  wire logic        out_en_b,
  input  wire logic        wr_en_b,
  input  wire logic        pdl_low,
  input  wire logic        pdl_high_volt,
  output logic [7:0]       dq_i = 8'h0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  mem [int];
  logic [1:0]  mode_r, setup_r;
  logic [15:0] cnt_r;
  logic        we_r, susp_r, ers_r, err_e_r, err_p_r;
  logic [18:0] lo_r, hi_r;
  logic [7:0]  st;
  assign st = {cnt_r == 16'h0 || susp_r, susp_r, err_e_r, err_p_r, 4'h0};
  // Erase block limits, boot block on top
  function automatic logic [37:0] span(input logic [18:0] a);
    if (a >= BOOT_TOP_BASE)
      return {BOOT_TOP_BASE, 19'h7ffff};
    if (a >= 19'h7a000)
      return {19'h7a000, 19'h7bfff};
    if (a >= 19'h78000)
      return {19'h78000, 19'h79fff};
    if (a >= 19'h60000)
      return {19'h60000, 19'h77fff};
    return {a & 19'h60000, a | 19'h1ffff};
  endfunction
  always @(posedge mclk) begin
    we_r <= wr_en_b;
    if (!out_en_b && !chip_en_b && !pdl_low)
      case (mode_r)
        2'd0: dq_i <= mem.exists(addr_o) ? mem[addr_o] : 8'hff;
        2'd1: dq_i <= st;
        default: dq_i <= SIG_CODE;
      endcase
    else
      dq_i <= ~dq_i;
    if (pdl_low) begin
      mode_r <= 2'd0;
      setup_r <= 2'd0;
      cnt_r <= 16'h0;
      {susp_r, ers_r, err_e_r, err_p_r} <= 4'h0;
    end else begin
      if (cnt_r != 16'h0 && !susp_r)
        cnt_r <= cnt_r - 16'h1;
      if (cnt_r == 16'h1 && ers_r && !susp_r) begin
        foreach (mem[k])
          if (k >= lo_r && k <= hi_r)
            mem[k] = 8'hff;
        ers_r <= 1'b0;
      end
      // Command taken as the write strobe rises
      if (wr_en_b && !we_r && !chip_en_b) begin
        mode_r <= 2'd1;
        setup_r <= 2'd0;
        if (setup_r != 2'd0 && addr_o >= BOOT_TOP_BASE && !pdl_high_volt)
          {err_e_r, err_p_r} <= {setup_r == 2'd2, setup_r == 2'd1};
        else if (setup_r == 2'd1) begin
          mem[addr_o] = dq_o;
          cnt_r <= 16'(PROG_CYC);
        end else if (setup_r == 2'd2 && dq_o == CMD_CONFIRM) begin
          {lo_r, hi_r} <= span(addr_o);
          ers_r <= 1'b1;
          cnt_r <= 16'(ERASE_CYC);
        end else if (setup_r == 2'd2)
          {err_e_r, err_p_r} <= 2'b11;
        else
          case (dq_o)
            CMD_READ_ARRAY: mode_r <= 2'd0;
            CMD_READ_SIG: mode_r <= 2'd2;
            CMD_PROG_A, CMD_PROG_B: setup_r <= 2'd1;
            CMD_ERASE_SETUP: setup_r <= 2'd2;
            CMD_CLEAR_STAT: {err_e_r, err_p_r} <= 2'b00;
            CMD_SUSPEND: susp_r <= ers_r;
            CMD_CONFIRM: susp_r <= 1'b0;
            default: ;
          endcase
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/fci_host_test.sv]
// Self-checking bench for the flash host controller
`default_nettype none
module fci_host_test
  import fci_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [16:0] WR = 17'h0;
  logic        mclk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, pwr_down_req = 1'b0, boot_unlock_req = 1'b0;
  fci_op_t     req_op = OP_READ;
  logic [18:0] req_addr = 19'h0, addr_o, pa;
  logic [7:0]  req_data = 8'h0, rsp_data, dq_i, dq_o, pd;
  logic        req_ready, rsp_valid, rsp_refused, chip_en_b, out_en_b, wr_en_b, dq_oe, pdl_low, pdl_high_volt;
  logic [16:0] notes[$];
  logic [16:0] nt;
  int          failures = 0;
  int          checked = 0;
  always #10 mclk = ~mclk;
  fci_host #(.BOOT_AT_TOP(1'b1)) dut (.mclk, .rst_b, .req_valid, .req_op, .req_addr, .req_data,
    .pwr_down_req, .boot_unlock_req, .req_ready, .rsp_valid, .rsp_data, .rsp_refused, .chip_en_b,
    .out_en_b, .wr_en_b, .addr_o, .dq_i, .dq_o, .dq_oe, .pdl_low, .pdl_high_volt);
  fci_flash_model #(.SIG_CODE(8'h5a)) flash (.mclk, .chip_en_b, .out_en_b, .wr_en_b, .addr_o,
    .dq_o, .pdl_low, .pdl_high_volt, .dq_i);
  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Note holds refused flag, data mask and expected data
  task automatic req(input fci_op_t op, input logic [18:0] a, input logic [7:0] d, input logic [16:0] note);
    int n;
    for (n = 0; n < 600 && req_ready !== 1'b1; n++)
      @(posedge mclk) #1;
    if (n == 600) begin
      failures++;
      end_sim();
    end
    notes.push_back(note);
    req_op = op;
    req_addr = a;
    req_data = d;
    req_valid = 1'b1;
    @(posedge mclk) #1;
    req_valid = 1'b0;
  endtask
  always @(posedge mclk) begin
    if (rst_b && rsp_valid === 1'b1) begin
      nt = notes.size() > 0 ? notes.pop_front() : 17'h1ffff;
      chk("rsp", {rsp_refused, rsp_data & nt[15:8]}, {nt[16], nt[7:0]});
    end
  end
  initial begin
    void'($urandom(32'h9751));
    repeat (10) @(posedge mclk);
    #1 rst_b = 1'b1;
    pwr_down_req = 1'b1;
    @(posedge mclk) #1;
    pwr_down_req = 1'b0;
    req(OP_READ_SIG, 19'h0, 8'h0, {1'b0, 8'hff, 8'h5a});
    req(OP_READ_ARRAY, 19'h12345, 8'h0, WR);
    req(OP_READ, 19'h12345, 8'h0, {1'b0, 8'hff, 8'hff});
    $display("test wake_read done");
    pa = {3'h2, 16'($urandom())};
    pd = 8'($urandom() & 32'h7f);
    req(OP_PROGRAM, pa, pd, WR);
    req(OP_READ_STATUS, 19'h0, 8'h0, {1'b0, 8'hff, 8'h00});
    repeat (80) @(posedge mclk) #1;
    req(OP_READ_STATUS, 19'h0, 8'h0, {1'b0, 8'hff, 8'h80});
    req(OP_READ_ARRAY, pa, 8'h0, WR);
    req(OP_READ, pa, 8'h0, {1'b0, 8'hff, pd});
    $display("test program done");
    req(OP_PROGRAM, 19'h7c010, pd, {1'b1, 8'h00, 8'h00});
    boot_unlock_req = 1'b1;
    // Unlock level must stand before the next request is taken
    repeat (3) @(posedge mclk) #1;
    req(OP_PROGRAM, 19'h7c010, ~pd, WR);
    repeat (80) @(posedge mclk) #1;
    req(OP_READ_ARRAY, 19'h7c010, 8'h0, WR);
    req(OP_READ, 19'h7c010, 8'h0, {1'b0, 8'hff, ~pd});
    boot_unlock_req = 1'b0;
    $display("test boot done");
    req(OP_ERASE, 19'h3ffff, 8'h0, WR);
    req(OP_SUSPEND, 19'h0, 8'h0, WR);
    req(OP_READ, 19'h0, 8'h0, {1'b0, 8'hff, 8'hc0});
    req(OP_RESUME, 19'h0, 8'h0, WR);
    req(OP_READ, 19'h0, 8'h0, {1'b0, 8'hc0, 8'h00});
    repeat (320) @(posedge mclk) #1;
    req(OP_CLEAR_STAT, 19'h0, 8'h0, WR);
    req(OP_READ_STATUS, 19'h0, 8'h0, {1'b0, 8'hff, 8'h80});
    req(OP_READ_ARRAY, pa, 8'h0, WR);
    req(OP_READ, pa, 8'h0, {1'b0, 8'hff, 8'hff});
    $display("test erase done");
    pwr_down_req = 1'b1;
    // Last read must finish before the host can drop the lock pin
    repeat (16) @(posedge mclk) #1;
    chk("pdl_low", {8'h0, pdl_low}, 9'h1);
    pwr_down_req = 1'b0;
    req(OP_READ, 19'h7c010, 8'h0, {1'b0, 8'hff, ~pd});
    for (int n = 0; n < 100 && notes.size() > 0; n++)
      @(posedge mclk) #1;
    chk("pending", 9'(notes.size()), 9'h0);
    $display("test power_down done");
    end_sim();
  end
endmodule
`default_nettype wire
